// *** inc/ssp_ctrl_pkg.sv ***
// constants for the serial port control block
package ssp_ctrl_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_ADDRESS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_BUFFER = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;
   localparam int BIT_WRITE_COLLISION_FLAG = 7;
   localparam int BIT_ROV = 6;
   localparam int BIT_EN = 5;
   localparam int BIT_REL = 4;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] ADDRESS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'hFF;
   localparam logic [3:0] MODE_SLAVE7 = 4'h6;
   localparam logic [3:0] MODE_SLAVE10 = 4'h7;
   localparam logic [3:0] MODE_MASK_SEL = 4'h9;
   localparam logic [3:0] MODE_FW_MASTER = 4'hB;
   localparam logic [3:0] MODE_SLAVE7_SP = 4'hE;
   localparam logic [3:0] MODE_SLAVE10_SP = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int STAT_START = 3;
   localparam int STAT_STOP = 4;
endpackage

// *** rtl/pin_sync.sv ***
// two flip-flop synchroniser for one pin level
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // level in and out
   input wire logic pin_in,
   output logic pin_out
);
   logic meta_q;
   logic sync_q;
   // idle bus level is high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end
   assign pin_out = sync_q;
endmodule
`default_nettype wire

// *** rtl/bus_cond_detect.sv ***
// start and stop condition detector on synchronised lines
`timescale 1ns/10ps
`default_nettype none
module bus_cond_detect (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // synchronised lines
   input wire logic clk_line,
   input wire logic data_line,
   // one-cycle events
   output logic start_seen,
   output logic stop_seen,
   output logic clk_fall
);
   logic clk_prev_q;
   logic data_prev_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_prev_q <= 1'b1;
         data_prev_q <= 1'b1;
      end else begin
         clk_prev_q <= clk_line;
         data_prev_q <= data_line;
      end
   end
   assign start_seen = clk_line && clk_prev_q && data_prev_q && !data_line;
   assign stop_seen = clk_line && clk_prev_q && !data_prev_q && data_line;
   assign clk_fall = clk_prev_q && !clk_line;
endmodule
`default_nettype wire

// *** rtl/serial_port_ctrl.sv ***
// control register logic of the serial port, reached over AXI4-Lite
// Overview of operation
// - a write to the shift buffer during a transmission sets the write collision flag, cleared only by software.
// - a byte arriving while the buffer still holds an unread byte sets the receive overflow flag.
// - port enable set takes the clock pin for the port, clear returns it to general use; the data pin is only sensed, never driven.
// - in slave modes clock release set frees the clock line and clear holds it low.
// - mode 0110 is 7-bit slave and mode 0111 is 10-bit slave.
// - mode 1011 is firmware master with the slave function idle.
// - after clock release clears, the clock is driven low only once seen low and held until clock release is set or slave mode ends.
// - once hardware clears clock release, the clock is held low once seen low, until software sets it or slave mode ends.
// - reset or port disable clears the start and stop status bits.
`timescale 1ns/10ps
`default_nettype none
module serial_port_ctrl
   import ssp_ctrl_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // transfer engine events
   input wire logic tx_busy,
   input wire logic rx_byte_done,
   input wire logic buffer_full,
   input wire logic hw_release_clear,
   // bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   // mode decode to the transfer engine
   output logic port_active,
   output logic slave_active,
   output logic addr_10bit,
   output logic cond_events_en,
   output logic fw_master,
   output logic [7:0] slave_address,
   output logic [7:0] address_mask,
   output logic buffer_write
);
   logic [7:0] control_q, control_d;
   logic [7:0] addr_q, mask_q;
   logic start_q, stop_q;
   logic hold_q;
   logic aw_q, w_q, bvalid_q, rvalid_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic [31:0] rdata_q;
   logic [1:0] bresp_q, rresp_q;
   logic scl_s, sda_s, start_ev, stop_ev;
   pin_sync u_scl_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(scl_in),
      .pin_out(scl_s)
   );
   pin_sync u_sda_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(sda_in),
      .pin_out(sda_s)
   );
   bus_cond_detect u_cond (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_line(scl_s),
      .data_line(sda_s),
      .start_seen(start_ev),
      .stop_seen(stop_ev),
      .clk_fall()
   );
   // mode decode
   wire [3:0] mode = control_q[3:0];
   wire enabled = control_q[BIT_EN];
   wire release_bit = control_q[BIT_REL];
   wire is_s7 = (mode == MODE_SLAVE7) || (mode == MODE_SLAVE7_SP);
   wire is_s10 = (mode == MODE_SLAVE10) || (mode == MODE_SLAVE10_SP);
   wire mask_sel = (mode == MODE_MASK_SEL);
   assign port_active = enabled;
   assign slave_active = enabled && (is_s7 || is_s10);
   assign addr_10bit = is_s10;
   assign cond_events_en = enabled && ((mode == MODE_SLAVE7_SP) ||
      (mode == MODE_SLAVE10_SP) || (mode == MODE_FW_MASTER));
   assign fw_master = enabled && (mode == MODE_FW_MASTER);
   assign slave_address = addr_q;
   assign address_mask = mask_q;
   // write path: address and data taken in either order
   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready = !w_q && !bvalid_q;
   wire aw_in = aw_q || (s_axi_awvalid && s_axi_awready);
   wire w_in = w_q || (s_axi_wvalid && s_axi_wready);
   wire [ADDR_W-1:0] wr_addr = aw_q ? awaddr_q : s_axi_awaddr;
   wire [7:0] wr_byte = w_q ? wdata_q : s_axi_wdata[7:0];
   wire wr_lane0 = w_q ? wstrb0_q : s_axi_wstrb[0];
   wire wr_fire = aw_in && w_in && !bvalid_q;
   wire wr_ok = (wr_addr == OFS_CONTROL) || (wr_addr == OFS_ADDRESS) ||
      (wr_addr == OFS_BUFFER);
   wire wr_ctrl = wr_fire && wr_lane0 && (wr_addr == OFS_CONTROL);
   wire wr_addr_reg = wr_fire && wr_lane0 && (wr_addr == OFS_ADDRESS);
   assign buffer_write = wr_fire && wr_lane0 && (wr_addr == OFS_BUFFER);
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bvalid_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) awaddr_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else begin
            aw_q <= aw_in;
            w_q <= w_in;
            if (s_axi_bready) bvalid_q <= 1'b0;
         end
      end
   end
   // control register: hardware set wins over software clear
   always_comb begin
      control_d = control_q;
      if (wr_ctrl) control_d = wr_byte;
      if (buffer_write && tx_busy) control_d[BIT_WRITE_COLLISION_FLAG] = 1'b1;
      if (rx_byte_done && buffer_full) control_d[BIT_ROV] = 1'b1;
      if (hw_release_clear && slave_active)
         control_d[BIT_REL] = 1'b0;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) control_q <= CONTROL_RESET;
      else control_q <= control_d;
   end
   // address or mask behind the same location
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_q <= ADDRESS_RESET;
         mask_q <= MASK_RESET;
      end else if (wr_addr_reg) begin
         if (mask_sel) mask_q <= wr_byte;
         else addr_q <= wr_byte;
      end
   end
   // start and stop status, cleared while disabled
   always_ff @(posedge aclk) begin
      if (!aresetn || !enabled) begin
         start_q <= 1'b0;
         stop_q <= 1'b0;
      end else if (start_ev) begin
         start_q <= 1'b1;
         stop_q <= 1'b0;
      end else if (stop_ev) begin
         start_q <= 1'b0;
         stop_q <= 1'b1;
      end
   end
   // clock stretch: pull low only after the line is seen low
   // pulling a line that is still high would cut its high phase short
   wire stretch = slave_active && !release_bit;
   always_ff @(posedge aclk) begin
      if (!aresetn) hold_q <= 1'b0;
      else if (!stretch) hold_q <= 1'b0;
      else if (!scl_s) hold_q <= 1'b1;
   end
   // the pin only ever pulls low; the pad sees the enable
   assign scl_out = 1'b0;
   // gated by the port enable so the pin is handed back in the same cycle
   assign scl_oe = hold_q && enabled;
   // read path
   wire [7:0] addr_view = mask_sel ? mask_q : addr_q;
   wire rd_ok = (s_axi_araddr == OFS_CONTROL) ||
      (s_axi_araddr == OFS_ADDRESS) || (s_axi_araddr == OFS_STATUS);
   logic [7:0] status_view;
   always_comb begin
      status_view = 8'h00;
      status_view[STAT_START] = start_q;
      status_view[STAT_STOP] = stop_q;
   end
   // unmapped reads answer with an error and zero data
   wire [7:0] rd_byte = (s_axi_araddr == OFS_CONTROL) ? control_q :
      (s_axi_araddr == OFS_ADDRESS) ? addr_view :
      (s_axi_araddr == OFS_STATUS) ? status_view : 8'h00;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_byte};
         rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   // checks
   a_write_collision_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      buffer_write && tx_busy |=> control_q[BIT_WRITE_COLLISION_FLAG])
      else $error("write collision not flagged");
   a_rov_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      rx_byte_done && buffer_full |=> control_q[BIT_ROV])
      else $error("receive overflow not flagged");
   a_pins_freed: assert property (@(posedge aclk) disable iff (!aresetn)
      !enabled |-> !scl_oe)
      else $error("clock pin driven while disabled");
   a_release_frees: assert property (@(posedge aclk) disable iff (!aresetn)
      release_bit |=> !scl_oe)
      else $error("clock held after release");
   a_mode_decode: assert property (@(posedge aclk) disable iff (!aresetn)
      enabled && mode == MODE_SLAVE10 |-> slave_active && addr_10bit)
      else $error("10-bit slave mode not decoded");
   a_master_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == MODE_FW_MASTER |-> !slave_active)
      else $error("slave active in firmware master");
   a_mask_alias: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_addr_reg && mask_sel |=> mask_q == $past(wr_byte)
      && $stable(addr_q))
      else $error("mask not written through address slot");
   sequence stretch_seen_low;
      stretch && !scl_s;
   endsequence
   a_stretch_low: assert property (@(posedge aclk) disable iff (!aresetn)
      stretch_seen_low ##1 stretch |-> scl_oe)
      else $error("clock not held after seen low");
   a_no_early_pull: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(hold_q) |-> !$past(scl_s))
      else $error("clock pulled before seen low");
   a_hw_clear_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      hw_release_clear && slave_active && !wr_ctrl |=> !release_bit)
      else $error("release bit not cleared by hardware");
   a_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      !enabled |=> !start_q && !stop_q)
      else $error("start stop bits not cleared");
   a_reserved_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == 4'h8 || mode == 4'hA || mode == 4'hC || mode == 4'hD
      |-> !slave_active && !cond_events_en)
      else $error("reserved mode active");
   a_write_collision_flag_sticky: assert property (
      @(posedge aclk) disable iff (!aresetn)
      control_q[BIT_WRITE_COLLISION_FLAG] && !wr_ctrl |=> control_q[BIT_WRITE_COLLISION_FLAG])
      else $error("write collision flag lost");
   a_write_collision_flag_quiet: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !control_q[BIT_WRITE_COLLISION_FLAG] && !wr_ctrl && !(buffer_write && tx_busy)
      |=> !control_q[BIT_WRITE_COLLISION_FLAG])
      else $error("write collision flag set without cause");
   a_rov_sticky: assert property (
      @(posedge aclk) disable iff (!aresetn)
      control_q[BIT_ROV] && !wr_ctrl |=> control_q[BIT_ROV])
      else $error("receive overflow flag lost");
   a_rov_quiet: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !control_q[BIT_ROV] && !wr_ctrl && !(rx_byte_done && buffer_full)
      |=> !control_q[BIT_ROV])
      else $error("receive overflow flag set without cause");
   a_hold_kept: assert property (
      @(posedge aclk) disable iff (!aresetn)
      scl_oe && stretch && !wr_ctrl |=> scl_oe)
      else $error("clock hold dropped before release");
   a_slave7_decode: assert property (
      @(posedge aclk) disable iff (!aresetn)
      enabled && mode == MODE_SLAVE7 |-> slave_active && !addr_10bit)
      else $error("7-bit slave mode not decoded");
   a_event_modes: assert property (
      @(posedge aclk) disable iff (!aresetn)
      enabled && (mode == MODE_SLAVE7_SP || mode == MODE_SLAVE10_SP)
      |-> slave_active && cond_events_en)
      else $error("event slave mode not decoded");
   a_addr_plain: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_addr_reg && !mask_sel |=> addr_q == $past(wr_byte)
      && $stable(mask_q))
      else $error("address not written at its own slot");
   a_idle_no_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !slave_active |=> !scl_oe)
      else $error("clock held outside slave modes");
endmodule
`default_nettype wire

// *** tb/i2c_master_model.sv ***
// behavioural outside bus master driving the clock and data lines
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
   // device pull on the clock line
   input wire logic scl_oe,
   // resolved lines seen by everyone
   output logic scl,
   output logic sda
);
   logic scl_drv = 1'b1;
   logic sda_drv = 1'b1;
   // set when a stretched clock never came back
   logic timed_out = 1'b0;
   // open drain with pull-ups: a low from any party wins
   assign scl = scl_drv & ~scl_oe;
   assign sda = sda_drv;
   // the clock moves inside frames, 160 ns per bit, and through set_clock; each change
   // lands 5 ns after a device clock edge, never on a sample
   task automatic set_clock(input logic lvl);
      #5;
      scl_drv = lvl;
   endtask
   task automatic start_cond();
      #5;
      sda_drv = 1'b0;
      #80;
      scl_drv = 1'b0;
      #80;
   endtask
   task automatic stop_cond();
      int n;
      #5;
      sda_drv = 1'b0;
      #80;
      scl_drv = 1'b1;
      // a stretching slave delays us, so wait for the line to rise
      for (n = 0; n < 100 && !scl; n++) begin
         #10;
      end
      if (n >= 100) timed_out = 1'b1;
      #80;
      sda_drv = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module tb;
   import ssp_ctrl_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic tx_busy = 0, rx_byte_done = 0, buffer_full = 0;
   logic hw_release_clear = 0;
   logic scl, sda, scl_oe, port_active, slave_active, addr_10bit;
   logic cond_events_en, fw_master, buffer_write;
   logic [7:0] slave_address, address_mask;
   logic [31:0] d;
   logic [12:0] rows [11] = '{{8'h36, 5'h18}, {8'h37, 5'h1C},
      {8'h3B, 5'h13}, {8'h3E, 5'h1A}, {8'h3F, 5'h1E}, {8'h38, 5'h10},
      {8'h3A, 5'h10}, {8'h3C, 5'h10}, {8'h3D, 5'h10}, {8'h39, 5'h10},
      {8'h16, 5'h00}};
   int tests_run = 0;
   int fail_count = 0;
   int bw_count = 0;
   always #10 aclk = ~aclk;
   always @(posedge aclk) begin
      if (buffer_write) bw_count <= bw_count + 1;
   end
   serial_port_ctrl serial_port_ctrl_i (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_busy,
      .rx_byte_done, .buffer_full, .hw_release_clear, .scl_in(scl),
      .scl_out(), .scl_oe, .sda_in(sda), .port_active, .slave_active,
      .addr_10bit, .cond_events_en, .fw_master, .slave_address,
      .address_mask, .buffer_write);
   i2c_master_model i2c_master_model_i (.scl_oe, .scl, .sda);
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic hang(input int n);
      if (n >= 50) begin
         chk(0, 1);
         give_verdict();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      int n;
      logic aw_ok, w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // each channel lets go once its own ready is seen
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) aw_ok = 1'b1;
         if (s_axi_wready) w_ok = 1'b1;
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end while (!(aw_ok && w_ok) && n < 50);
      do begin
         @(posedge aclk);
         n++;
      end while (!s_axi_bvalid && n < 50);
      r = s_axi_bresp;
      // bready stays up: dropping it here clashes with the next raise
      hang(n);
   endtask
   task automatic rd(input logic [3:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!s_axi_arready && n < 50);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (!s_axi_rvalid && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      hang(n);
   endtask
   task automatic pulse_rx();
      rx_byte_done <= 1'b1;
      @(posedge aclk);
      rx_byte_done <= 1'b0;
      @(posedge aclk);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(OFS_CONTROL);
      chk(d, CONTROL_RESET);
      chk(address_mask, MASK_RESET);
      foreach (rows[i]) begin
         wr(OFS_CONTROL, rows[i][12:5]);
         rd(OFS_CONTROL);
         chk(d, rows[i][12:5]);
         chk({port_active, slave_active, addr_10bit, cond_events_en,
            fw_master}, rows[i][4:0]);
      end
      rd(OFS_BUFFER);
      chk(r, RESP_SLVERR);
      wr(4'h1, 8'h55);
      chk(r, RESP_SLVERR);
      // mask redirection, then back to the plain address
      wr(OFS_CONTROL, 8'h39);
      wr(OFS_ADDRESS, 8'h5A);
      chk(address_mask, 8'h5A);
      chk(slave_address, ADDRESS_RESET);
      rd(OFS_ADDRESS);
      chk(d, 8'h5A);
      wr(OFS_CONTROL, 8'h36);
      wr(OFS_ADDRESS, 8'hA4);
      rd(OFS_ADDRESS);
      chk({d[7:0], address_mask}, 16'hA45A);
      // collision: buffer written during a transmission
      tx_busy <= 1'b1;
      wr(OFS_BUFFER, 8'h11);
      tx_busy <= 1'b0;
      rd(OFS_CONTROL);
      chk(d, 8'hB6);
      wr(OFS_CONTROL, 8'h36);
      wr(OFS_BUFFER, 8'h12);
      rd(OFS_CONTROL);
      chk(d, 8'h36);
      chk(bw_count, 32'h00000002);
      // overflow only while an unread byte is held
      buffer_full <= 1'b1;
      pulse_rx();
      rd(OFS_CONTROL);
      chk(d, 8'h76);
      wr(OFS_CONTROL, 8'h36);
      buffer_full <= 1'b0;
      pulse_rx();
      rd(OFS_CONTROL);
      chk(d, 8'h36);
      // start and stop bits, cleared by disable
      wr(OFS_CONTROL, 8'h3E);
      i2c_master_model_i.start_cond();
      rd(OFS_STATUS);
      chk(d[4:3], 2'b01);
      i2c_master_model_i.stop_cond();
      chk(i2c_master_model_i.timed_out, 1'b0);
      rd(OFS_STATUS);
      chk(d[4:3], 2'b10);
      wr(OFS_CONTROL, 8'h1E);
      rd(OFS_STATUS);
      chk(d[4:3], 2'b00);
      // stretching only after the line is seen low
      wr(OFS_CONTROL, 8'h26);
      repeat (8) @(posedge aclk);
      chk(scl_oe, 1'b0);
      i2c_master_model_i.set_clock(1'b0);
      repeat (4) @(posedge aclk);
      i2c_master_model_i.set_clock(1'b1);
      repeat (3) @(posedge aclk);
      chk({scl_oe, scl}, 2'b10);
      wr(OFS_CONTROL, 8'h36);
      repeat (2) @(posedge aclk);
      chk({scl_oe, scl}, 2'b01);
      // hardware clears the release bit, the clock is held low again once seen low
      hw_release_clear <= 1'b1;
      @(posedge aclk);
      hw_release_clear <= 1'b0;
      rd(OFS_CONTROL);
      chk(d, 8'h26);
      i2c_master_model_i.set_clock(1'b0);
      repeat (4) @(posedge aclk);
      i2c_master_model_i.set_clock(1'b1);
      repeat (5) @(posedge aclk);
      chk(scl, 1'b0);
      // switching the port off hands the clock pin back at once
      wr(OFS_CONTROL, 8'h06);
      chk({scl_oe, scl}, 2'b01);
      wr(OFS_CONTROL, 8'h36);
      repeat (2) @(posedge aclk);
      chk(scl, 1'b1);
      // reset in mid-run, with a start condition on record
      i2c_master_model_i.start_cond();
      rd(OFS_STATUS);
      chk(d[4:3], 2'b01);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(OFS_CONTROL);
      chk({d[7:0], scl_oe}, {CONTROL_RESET, 1'b0});
      chk({slave_address, address_mask}, {ADDRESS_RESET, MASK_RESET});
      rd(OFS_STATUS);
      chk(d, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
